//--- hdl/adc_special_event_trigger.sv
// converter start logic with axi4-lite control registers
// assumes the compare units and counter sit in the same clock domain
`timescale 1ns/1ps
module adc_special_event_trigger
    import trig_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        first_compare_pulse,
    input  wire logic        second_compare_pulse,
    input  wire logic        conversion_done_in,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             go_done,
    output logic             conversion_start,
    output logic             counter_clear
);
    logic [31:0]    ctrl_reg;
    logic [15:0]    trig_count_reg;
    logic [7:0]     conv_cnt_reg;
    conv_state_t    state_reg;
    logic           start_conv;
    logic           clear_cnt;
    logic           sw_go;
    logic           conv_end;
    logic           aw_held_reg;
    logic           w_held_reg;
    logic [31:0]    awaddr_reg;
    logic [31:0]    wdata_reg;
    logic [3:0]     wstrb_reg;
    compare_event_t ev1;
    compare_event_t ev2;

    assign ev1 = '{pulse: first_compare_pulse, mode: ctrl_reg[CTRL_MODE1_LO +: 4]};
    assign ev2 = '{pulse: second_compare_pulse, mode: ctrl_reg[CTRL_MODE2_LO +: 4]};

    trig_qualify u_qual (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .first_event    (ev1),
        .second_event   (ev2),
        .use_first_unit (ctrl_reg[CTRL_SRC_BIT]),
        .converter_on   (ctrl_reg[CTRL_ON_BIT]),
        .start_conv     (start_conv),
        .clear_counter  (clear_cnt)
    );

    // write channel capture
    wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 32'h0000_0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg[7:0] == CTRL_OFFSET[7:0]) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control register, go bit handled separately
    assign sw_go = do_write && awaddr_reg[7:0] == CTRL_OFFSET[7:0]
                   && wstrb_reg[0] && wdata_reg[CTRL_GO_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (do_write && awaddr_reg[7:0] == CTRL_OFFSET[7:0]) begin
            for (int i = 0; i < 4; i++) begin
                if (wstrb_reg[i]) begin
                    ctrl_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
                end
            end
        end
    end

    // conversion sequencer
    assign conv_end = conversion_done_in || conv_cnt_reg == 8'(CONV_LEN - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg        <= IDLE;
            go_done          <= 1'b0;
            conv_cnt_reg     <= 8'h00;
            conversion_start <= 1'b0;
        end else begin
            conversion_start <= 1'b0;
            case (state_reg)
                IDLE: begin
                    if ((start_conv || sw_go) && ctrl_reg[CTRL_ON_BIT]) begin
                        state_reg        <= CONVERTING;
                        go_done          <= 1'b1;
                        conversion_start <= 1'b1;
                        conv_cnt_reg     <= 8'h00;
                    end
                end
                CONVERTING: begin
                    conv_cnt_reg <= conv_cnt_reg + 8'h01;
                    if (conv_end || !ctrl_reg[CTRL_ON_BIT]) begin
                        state_reg <= IDLE;
                        go_done   <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= IDLE;
                    go_done   <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_clear  <= 1'b0;
            trig_count_reg <= 16'h0000;
        end else begin
            counter_clear <= clear_cnt;
            if (clear_cnt) begin
                trig_count_reg <= trig_count_reg + 16'h0001;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr[7:0])
                    CTRL_OFFSET[7:0]:   s_axi_rdata <= {ctrl_reg[31:2], go_done, ctrl_reg[0]};
                    STATUS_OFFSET[7:0]: s_axi_rdata <= {30'h0, state_reg == CONVERTING, go_done};
                    COUNT_OFFSET[7:0]:  s_axi_rdata <= {16'h0000, trig_count_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // adc_special_event_trigger

//--- hdl/trig_pkg.sv
// constants and types for the converter start logic
// assumes a single system clock domain
// Overview of operation
// - trigger starts conversion only if mode field is 1011 and converter on
// - accepted trigger sets go/done, starting conversion as a software set would
// - same trigger clears the sixteen-bit counter to zero
// - converter off means trigger ignored, go/done unchanged, no conversion
// - counter still cleared on trigger while converter off
// - trigger source selectable at run time by ctrl bit 2, second (0) or first (1) compare unit
package trig_pkg;
    localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
    localparam logic [31:0] COUNT_OFFSET  = 32'h0000_0008;
    localparam logic [3:0]  SPECIAL_EVENT_MODE = 4'hB;
    localparam int          CONV_CYCLES   = 12;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // ctrl fields
    localparam int CTRL_ON_BIT   = 0;
    localparam int CTRL_GO_BIT   = 1;
    localparam int CTRL_SRC_BIT  = 2;
    localparam int CTRL_MODE2_LO = 4;
    localparam int CTRL_MODE1_LO = 8;

    typedef struct packed {
        logic        pulse;
        logic [3:0]  mode;
    } compare_event_t;

    typedef enum logic [1:0] {
        IDLE,
        CONVERTING
    } conv_state_t;
endpackage

//--- hdl/trig_qualify.sv
// trigger qualification for the special event
// assumes compare unit pulses are one cycle wide
`timescale 1ns/1ps
module trig_qualify
    import trig_pkg::*;
(
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire trig_pkg::compare_event_t first_event,
    input  wire trig_pkg::compare_event_t second_event,
    input  wire logic           use_first_unit,
    input  wire logic           converter_on,
    output logic                start_conv,
    output logic                clear_counter
);
    compare_event_t sel;

    always_comb begin
        sel = use_first_unit ? first_event : second_event;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_conv    <= 1'b0;
            clear_counter <= 1'b0;
        end else begin
            clear_counter <= sel.pulse && sel.mode == SPECIAL_EVENT_MODE;
            start_conv    <= sel.pulse && sel.mode == SPECIAL_EVENT_MODE
                             && converter_on;
        end
    end
endmodule // trig_qualify

//--- tb/trig_check_sva.sv
// assertions on the converter start logic ports
// assumes it is bound into adc_special_event_trigger
`timescale 1ns/1ps
module trig_check #(
    parameter int CONV_LEN = 12
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic first_compare_pulse,
    input wire logic second_compare_pulse,
    input wire logic conversion_done_in,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic go_done,
    input wire logic conversion_start,
    input wire logic counter_clear
);
    localparam int CONV_MAX = CONV_LEN + 2;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_start_go; conversion_start |-> go_done; endproperty
    a_start_go: assert property (p_start_go) else $error("start without go");
    property p_start_clr;
        conversion_start && $past(first_compare_pulse || second_compare_pulse, 2)
            |-> counter_clear;
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("start without clear");
    property p_clr_cause;
        counter_clear |-> $past(first_compare_pulse || second_compare_pulse, 2);
    endproperty
    a_clr_cause: assert property (p_clr_cause) else $error("clear without pulse");
    property p_start_idle; conversion_start |-> !$past(go_done); endproperty
    a_start_idle: assert property (p_start_idle) else $error("start while busy");
    property p_one_start; conversion_start |=> !conversion_start; endproperty
    a_one_start: assert property (p_one_start) else $error("start repeated");
    property p_conv_end; conversion_start |-> ##[1:CONV_MAX] !go_done; endproperty
    a_conv_end: assert property (p_conv_end) else $error("go stuck");
    property p_done_in; conversion_done_in && go_done |-> ##[1:2] !go_done; endproperty
    a_done_in: assert property (p_done_in) else $error("done ignored");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
endmodule // trig_check

bind adc_special_event_trigger trig_check #(.CONV_LEN(CONV_LEN)) chk_inst (.aclk, .aresetn,
    .first_compare_pulse, .second_compare_pulse, .conversion_done_in, .s_axi_bvalid,
    .s_axi_bready, .go_done, .conversion_start, .counter_clear);

//--- tb/counter_model.sv
// sixteen-bit counter beside the converter
// assumes clear is a pulse in the aclk domain
`timescale 1ns/1ps
module counter_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clear,
    output logic      [15:0] count
);
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end
endmodule // counter_model

//--- tb/adc_special_event_trigger_test.sv
// bench for the converter start logic
// assumes trig_pkg, design and counter_model compiled first
`timescale 1ns/1ps
module adc_special_event_trigger_test;
    import trig_pkg::*;
    logic aclk = 0, aresetn = 0, first_compare_pulse = 0, second_compare_pulse = 0;
    logic conversion_done_in = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, go_done, conversion_start, counter_clear;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] count;
    int          err_count = 0, samples_checked = 0;
    always #2 aclk = ~aclk;
    adc_special_event_trigger #(.CONV_LEN(12)) DUT (.aclk, .aresetn, .first_compare_pulse,
        .second_compare_pulse, .conversion_done_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .go_done, .conversion_start,
        .counter_clear);
    counter_model timer (.aclk, .aresetn, .clear(counter_clear), .count);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] addr, data, input logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
    endtask
    task automatic rdc(input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        @(posedge aclk);
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk("rdata", exp, s_axi_rdata);
        chk("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
    endtask
    task automatic trig(input logic f, s, est, ecl, ego);
        logic st, cl, gd;
        {st, cl, gd} = 3'h0;
        @(posedge aclk);
        first_compare_pulse <= f;
        second_compare_pulse <= s;
        @(posedge aclk);
        first_compare_pulse <= 1'h0;
        second_compare_pulse <= 1'h0;
        repeat (3) begin
            @(posedge aclk);
            #1;
            st |= conversion_start;
            gd |= go_done;
            if (counter_clear) begin
                cl = 1'h1;
                @(posedge aclk);
                #1 chk("count", 32'h0, {16'h0, count});
            end
        end
        chk("start", {31'h0, est}, {31'h0, st});
        chk("clear", {31'h0, ecl}, {31'h0, cl});
        chk("go_done", {31'h0, ego}, {31'h0, gd});
        $display("trigger test done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rdc(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
        wr(CTRL_OFFSET, 32'h0000_00B1, RESP_OKAY);
        trig(1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        repeat (16) @(posedge aclk);
        #1 chk("go_done", 32'h0, {31'h0, go_done});
        wr(CTRL_OFFSET, 32'h0000_00A1, RESP_OKAY);
        trig(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        wr(CTRL_OFFSET, 32'h0000_0B05, RESP_OKAY);
        trig(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        trig(1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
        repeat (16) @(posedge aclk);
        wr(CTRL_OFFSET, 32'h0000_00B0, RESP_OKAY);
        trig(1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        wr(CTRL_OFFSET, 32'h0000_00B1, RESP_OKAY);
        trig(1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        @(posedge aclk);
        conversion_done_in <= 1'h1;
        @(posedge aclk);
        conversion_done_in <= 1'h0;
        repeat (2) @(posedge aclk);
        #1 chk("go_done", 32'h0, {31'h0, go_done});
        wr(CTRL_OFFSET, 32'h0000_00B3, RESP_OKAY);
        rdc(STATUS_OFFSET, 32'h0000_0003, RESP_OKAY);
        trig(1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
        repeat (16) @(posedge aclk);
        #1 chk("go_done", 32'h0, {31'h0, go_done});
        rdc(COUNT_OFFSET, 32'h0000_0005, RESP_OKAY);
        rdc(STATUS_OFFSET, 32'h0000_0000, RESP_OKAY);
        wr(32'h0000_0010, 32'h0000_0000, RESP_SLVERR);
        rdc(CTRL_OFFSET, 32'h0000_00B1, RESP_OKAY);
        rdc(32'h0000_0010, 32'h0, RESP_SLVERR);
        $display("register test done");
        end_sim;
    end
endmodule // adc_special_event_trigger_test
